// File: tps_top.sv
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// (RULE_01) Backplane structured receive clock runs at 4.096 MHz for sampling.
// (RULE_02) Generic structured receive clock is 1.544 or 2.048 MHz.
// (RULE_03) Unstructured receive clock is 1.544 MHz DS1 or 2.048 MHz E1.
// (RULE_04) Backplane structured transmit clock driven at 4.096 MHz.
// (RULE_05) Generic structured transmit clock 1.544 or 2.048 MHz DS1, 2.048 E1.
// (RULE_06) Unstructured transmit clock 1.544 MHz DS1, 2.048 MHz E1.
// (RULE_07) Structured receive aligns to frame pulse; unstructured ignores it.
// (RULE_08) Transmit frame pulse marks frames or multiframes; unused unstructured.
// (RULE_09) Receive data is serial stream, channelised or unframed.
// (RULE_10) Transmit data is serial stream of 24 or 32 channels.
// (RULE_11) Receive signalling is CAS structured, loss of signal unstructured. Structured CAS on the receive signalling input is ignored, not captured.
// (RULE_12) Structured transmit signalling sent serially, frame aligned.
// (RULE_13) Unstructured transmit signalling is programmed per-port level.
// (RULE_14) Each of eight ports configured independently.
// (RULE_15) Transmit bits launched on edge opposite far-end sampling.
module tps_top #(
   parameter int NPORT = tps_pkg::NUM_PORTS
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic [11:0]      paddr,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic                  irq,
   input  wire logic [NPORT-1:0] rx_line_clock,
   input  wire logic [NPORT-1:0] rx_frame_pulse,
   input  wire logic [NPORT-1:0] rx_pcm_data,
   input  wire logic [NPORT-1:0] rx_signalling_or_los,
   output logic      [NPORT-1:0] tx_line_clock,
   output logic      [NPORT-1:0] tx_frame_pulse,
   output logic      [NPORT-1:0] tx_pcm_data,
   output logic      [NPORT-1:0] tx_signalling_or_los
);
   tps_pkg::tps_cfg_s  cfg_ff    [NPORT];
   logic [31:0]        txw_ff    [NPORT];
   logic [31:0]        rxw       [NPORT];
   logic [NPORT-1:0]   los_lvl_ff;
   logic [15:0]        status_ff;
   logic [15:0]        mask_ff;
   logic [NPORT-1:0]   frame_evt;
   logic [NPORT-1:0]   los;
   logic [NPORT-1:0]   los_d_ff;
   logic [4*NPORT-1:0] sync_in;
   logic [4*NPORT-1:0] sync_out;
   logic               wr_en;
   logic               rd_en;
   logic [2:0]         pidx;
   logic               hit;
   logic [15:0]        evt;
   logic [15:0]        rd_clr;
   logic [31:0]        rdata;

   assign sync_in = {rx_line_clock, rx_frame_pulse, rx_pcm_data, rx_signalling_or_los};
   tps_sync #(.W(4*NPORT)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (sync_in),
      .q       (sync_out)
   );

   for (genvar p = 0; p < NPORT; p++) begin : g_port
      tps_pkg::tps_line_s rl;
      tps_pkg::tps_line_s tl;
      assign rl.clk   = sync_out[3*NPORT+p];
      assign rl.frame = sync_out[2*NPORT+p];
      assign rl.data  = sync_out[NPORT+p];
      assign rl.sig   = sync_out[p];
      tps_port u_port ( // RULE_14
         .pclk         (pclk),
         .presetn      (presetn),
         .ce           (ce),
         .cfg          (cfg_ff[p]),
         .los_level    (los_lvl_ff[p]),
         .tx_word      (txw_ff[p]),
         .rx_sync      (rl),
         .tx_line      (tl),
         .rx_word      (rxw[p]),
         .rx_frame_evt (frame_evt[p]),
         .rx_los       (los[p])
      );
      assign tx_line_clock[p]        = tl.clk;
      assign tx_frame_pulse[p]       = tl.frame;
      assign tx_pcm_data[p]          = tl.data;
      assign tx_signalling_or_los[p] = tl.sig;
   end

   assign pready  = 1'b1;
   assign wr_en   = ce && psel && penable && pwrite;
   assign rd_en   = ce && psel && penable && !pwrite;
   assign pidx    = paddr[4:2];
   assign hit     = (paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_CTRL1 ||
                    (paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_CTRL3 ||
                    (paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_TXDATA ||
                    (paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_RXDATA ||
                    paddr == tps_pkg::OFS_STATUS || paddr == tps_pkg::OFS_MASK ||
                    paddr == tps_pkg::OFS_LOS;
   assign pslverr = psel && penable && !hit;

   // Per-port configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NPORT; i++) begin
            cfg_ff[i] <= tps_pkg::CTRL1_RST;
            txw_ff[i] <= '0;
         end
         los_lvl_ff <= '0;
      end else if (wr_en) begin
         if ((paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_CTRL1) begin
            cfg_ff[pidx] <= {pwdata[tps_pkg::CF_ENABLE], pwdata[tps_pkg::CF_E1],
                             pwdata[tps_pkg::CF_UNSTRUCT], pwdata[tps_pkg::CF_BACKPLANE],
                             pwdata[tps_pkg::CF_DS1_2048], pwdata[tps_pkg::CF_MF]}; // RULE_14
         end else if ((paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_CTRL3) begin
            los_lvl_ff[pidx] <= pwdata[0]; // RULE_13
         end else if ((paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_TXDATA) begin
            txw_ff[pidx] <= pwdata;
         end
      end
   end

   // Interrupt status: set wins over read clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         los_d_ff <= '0;
      end else if (ce) begin
         los_d_ff <= los;
      end
   end
   assign evt    = {los & ~los_d_ff, frame_evt};
   assign rd_clr = (rd_en && paddr == tps_pkg::OFS_STATUS) ? 16'hFFFF : 16'h0000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= '0;
         mask_ff   <= '0;
      end else if (ce) begin
         status_ff <= (status_ff & ~rd_clr) | evt;
         if (wr_en && paddr == tps_pkg::OFS_MASK) begin
            mask_ff <= pwdata[15:0];
         end
      end
   end
   assign irq = |(status_ff & mask_ff);

   always_comb begin
      rdata = 32'h0000_0000;
      if ((paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_CTRL1) begin
         rdata[5:0] = {cfg_ff[pidx].mf, cfg_ff[pidx].ds1_2048, cfg_ff[pidx].backplane,
                       cfg_ff[pidx].unstruct, cfg_ff[pidx].e1, cfg_ff[pidx].enable};
      end else if ((paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_CTRL3) begin
         rdata[0] = los_lvl_ff[pidx];
      end else if ((paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_TXDATA) begin
         rdata = txw_ff[pidx];
      end else if ((paddr & ~tps_pkg::OFS_PORT_MASK) == tps_pkg::OFS_RXDATA) begin
         rdata = rxw[pidx];
      end else if (paddr == tps_pkg::OFS_STATUS) begin
         rdata[15:0] = status_ff;
      end else if (paddr == tps_pkg::OFS_MASK) begin
         rdata[15:0] = mask_ff;
      end else if (paddr == tps_pkg::OFS_LOS) begin
         rdata[NPORT-1:0] = los; // RULE_11
      end
   end
   assign prdata = rdata;
endmodule
`default_nettype wire

// File: tps_pkg.sv
package tps_pkg;
   localparam int          NUM_PORTS        = 8;
   // System clock 250 MHz, times in kHz
   localparam int          PCLK_KHZ         = 250000;
   localparam int          RATE_4096_KHZ    = 4096;
   localparam int          RATE_2048_KHZ    = 2048;
   localparam int          RATE_1544_KHZ    = 1544;
   // Half-period counts in pclk cycles, rounded down
   localparam int          HALF_4096        = PCLK_KHZ / (2 * RATE_4096_KHZ);
   localparam int          HALF_2048        = PCLK_KHZ / (2 * RATE_2048_KHZ);
   localparam int          HALF_1544        = PCLK_KHZ / (2 * RATE_1544_KHZ);
   localparam int          DIV_W            = 8;
   // Bits per frame
   localparam int          BITS_DS1         = 193;
   localparam int          BITS_E1          = 256;
   localparam int          FRAMES_MF        = 16;
   localparam int          BIT_CNT_W        = 10;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL1        = 12'h000;
   localparam logic [11:0] OFS_CTRL3        = 12'h020;
   localparam logic [11:0] OFS_STATUS       = 12'h040;
   localparam logic [11:0] OFS_MASK         = 12'h044;
   localparam logic [11:0] OFS_LOS          = 12'h048;
   localparam logic [11:0] OFS_TXDATA       = 12'h060;
   localparam logic [11:0] OFS_RXDATA       = 12'h080;
   localparam logic [11:0] OFS_PORT_MASK    = 12'h01C;
   // Control 1 field positions
   localparam int          CF_ENABLE        = 0;
   localparam int          CF_E1            = 1;
   localparam int          CF_UNSTRUCT      = 2;
   localparam int          CF_BACKPLANE     = 3;
   localparam int          CF_DS1_2048      = 4;
   localparam int          CF_MF            = 5;
   localparam logic [5:0]  CTRL1_RST        = 6'h00;
   // Status bits per port: bit p frame seen, bit p+8 los edge
   localparam int          ST_LOS_OFS       = 8;
   typedef struct packed {
      logic enable;
      logic e1;
      logic unstruct;
      logic backplane;
      logic ds1_2048;
      logic mf;
   } tps_cfg_s;
   typedef struct packed {
      logic clk;
      logic frame;
      logic data;
      logic sig;
   } tps_line_s;
endpackage

// File: tps_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tps_sync #(
   parameter int W = 4
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         q       <= '0;
      end else if (ce) begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// File: tps_port.sv
`timescale 1ns/10ps
`default_nettype none
module tps_port (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               ce,
   input  wire tps_pkg::tps_cfg_s  cfg,
   input  wire logic               los_level,
   input  wire logic [31:0]        tx_word,
   input  wire tps_pkg::tps_line_s rx_sync,
   output tps_pkg::tps_line_s      tx_line,
   output logic [31:0]             rx_word,
   output logic                    rx_frame_evt,
   output logic                    rx_los
);
   logic [tps_pkg::DIV_W-1:0]     div_ff;
   logic [tps_pkg::DIV_W-1:0]     half;
   logic                          tclk_ff;
   logic                          fall;
   logic                          bit_ce;
   logic                          launch_ff;
   logic                          nxt_tclk;
   logic [tps_pkg::BIT_CNT_W-1:0] tbit_ff;
   logic [tps_pkg::BIT_CNT_W-1:0] last_bit;
   logic [3:0]                    tfrm_ff;
   logic                          rclk_d_ff;
   logic                          rfrm_d_ff;
   logic                          rise;
   logic [4:0]                    rbit_ff;
   logic [31:0]                   rsh_ff;
   logic [4:0]                    tidx;

   always_comb begin
      if (cfg.backplane && !cfg.unstruct) begin
         half = tps_pkg::DIV_W'(tps_pkg::HALF_4096); // RULE_04
      end else if (cfg.e1 || (cfg.ds1_2048 && !cfg.unstruct)) begin
         half = tps_pkg::DIV_W'(tps_pkg::HALF_2048); // RULE_05
      end else begin
         half = tps_pkg::DIV_W'(tps_pkg::HALF_1544); // RULE_06
      end
   end
   assign last_bit = (cfg.e1 || cfg.ds1_2048) ? tps_pkg::BIT_CNT_W'(tps_pkg::BITS_E1 - 1)
                                              : tps_pkg::BIT_CNT_W'(tps_pkg::BITS_DS1 - 1);
   assign fall     = tclk_ff && (div_ff == half - 1'b1);
   assign nxt_tclk = cfg.enable && ((div_ff == half - 1'b1) ? ~tclk_ff : tclk_ff);
   // One bit per tx clock, launched a pclk after it falls
   assign bit_ce   = launch_ff;

   // Transmit clock divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff    <= '0;
         tclk_ff   <= 1'b0;
         launch_ff <= 1'b0;
      end else if (ce) begin
         launch_ff <= fall; // RULE_15
         if (!cfg.enable) begin
            div_ff  <= '0;
            tclk_ff <= 1'b0;
         end else if (div_ff == half - 1'b1) begin
            div_ff  <= '0;
            tclk_ff <= ~tclk_ff; // RULE_04 RULE_05 RULE_06
         end else begin
            div_ff <= div_ff + 1'b1;
         end
      end
   end

   // Transmit bit and frame counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tbit_ff <= '0;
         tfrm_ff <= '0;
      end else if (ce && cfg.enable && bit_ce) begin
         if (tbit_ff == last_bit) begin
            tbit_ff <= '0;
            tfrm_ff <= tfrm_ff + 1'b1;
         end else begin
            tbit_ff <= tbit_ff + 1'b1;
         end
      end
   end

   assign tidx = 5'(31 - tbit_ff[4:0]);
   // Outputs change on falling tx clock, far end samples on rising
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_line <= '0;
      end else if (ce) begin
         tx_line.clk <= nxt_tclk;
         if (bit_ce) begin
            tx_line.data <= tx_word[tidx]; // RULE_10 RULE_15
         end
         if (cfg.unstruct) begin
            tx_line.sig   <= los_level; // RULE_13
            tx_line.frame <= 1'b0; // RULE_08
         end else if (bit_ce) begin
            tx_line.sig   <= tx_word[tidx]; // RULE_12 RULE_15
            tx_line.frame <= (tbit_ff == last_bit) &&
                             (!cfg.mf || tfrm_ff == 4'(tps_pkg::FRAMES_MF - 1)); // RULE_08
         end
      end
   end

   // Receive sampling on rising edge of the line clock
   assign rise = rx_sync.clk && !rclk_d_ff; // RULE_01 RULE_02 RULE_03
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rclk_d_ff    <= 1'b0;
         rfrm_d_ff    <= 1'b0;
         rbit_ff      <= '0;
         rsh_ff       <= '0;
         rx_word      <= '0;
         rx_frame_evt <= 1'b0;
         rx_los       <= 1'b0;
      end else if (ce) begin
         rclk_d_ff    <= rx_sync.clk;
         rx_frame_evt <= 1'b0;
         rx_los       <= cfg.unstruct && rx_sync.sig; // RULE_11
         if (rise && cfg.enable) begin
            rfrm_d_ff <= rx_sync.frame;
            rsh_ff    <= {rsh_ff[30:0], rx_sync.data}; // RULE_09
            if (!cfg.unstruct && rx_sync.frame && !rfrm_d_ff) begin
               rbit_ff      <= 5'd1; // RULE_07
               rx_frame_evt <= 1'b1;
            end else begin
               rbit_ff <= rbit_ff + 1'b1;
            end
            if (rbit_ff == 5'd31) begin
               rx_word <= {rsh_ff[30:0], rx_sync.data};
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: tps_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module tps_checker #(
   parameter int NPORT = 8
) (
   input wire logic             pclk,
   input wire logic             presetn,
   input wire logic             ce,
   input wire logic [11:0]      paddr,
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pslverr,
   input wire logic             irq,
   input wire logic [NPORT-1:0] tx_line_clock,
   input wire logic [NPORT-1:0] tx_frame_pulse,
   input wire logic [NPORT-1:0] tx_pcm_data,
   input wire logic [NPORT-1:0] tx_signalling_or_los
);
   logic [7:0]  gap_ff;
   logic        clk_ff;
   logic [15:0] mask_ff;
   logic [5:0]  cfg_ff;
   logic        lvl_ff;
   logic [2:0]  quiet_ff;
   logic [7:0]  half;
   logic        acc;
   logic        clr;
   assign acc = psel && penable && ce;
   assign clr = acc && (pwrite ? paddr == tps_pkg::OFS_MASK : paddr == tps_pkg::OFS_STATUS);
   assign half = (cfg_ff[3] && !cfg_ff[2]) ? 8'(tps_pkg::HALF_4096) :
                 (cfg_ff[1] || (cfg_ff[4] && !cfg_ff[2])) ? 8'(tps_pkg::HALF_2048) :
                 8'(tps_pkg::HALF_1544);
   // Cycles since port 0 tx clock moved
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_ff <= 1'b0;
         gap_ff <= 8'hFF;
      end else begin
         clk_ff <= tx_line_clock[0];
         gap_ff <= (tx_line_clock[0] != clk_ff) ? 8'h01 : gap_ff + 8'(gap_ff != 8'hFF);
      end
   end
   // Port 0 setup seen on the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_ff <= 16'h0000;
         cfg_ff <= 6'h00;
         lvl_ff <= 1'b0;
         quiet_ff <= 3'h0;
      end else begin
         if (acc && pwrite && paddr == tps_pkg::OFS_MASK) mask_ff <= pwdata[15:0];
         if (acc && pwrite && paddr == tps_pkg::OFS_CTRL1) cfg_ff <= pwdata[5:0];
         if (acc && pwrite && paddr == tps_pkg::OFS_CTRL3) lvl_ff <= pwdata[0];
         quiet_ff <= (acc && pwrite) ? 3'h0 : quiet_ff + 3'(quiet_ff != 3'h7);
      end
   end
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_half_period: assert property (
      $changed(tx_line_clock[0]) && cfg_ff[0] && gap_ff <= 8'h50 |-> gap_ff == half)
      else $error("tx clock half period wrong");
   a_idle_clock: assert property (
      !cfg_ff[0] && quiet_ff == 3'h7 |-> $stable(tx_line_clock[0]))
      else $error("tx clock runs on disabled port");
   a_data_launch: assert property (
      $changed(tx_pcm_data[0]) && cfg_ff[0] && gap_ff <= 8'h50
      |-> !tx_line_clock[0] && gap_ff < 8'h04)
      else $error("tx data moved away from falling clock");
   a_sig_launch: assert property (
      $changed(tx_signalling_or_los[0]) && cfg_ff[0] && !cfg_ff[2] && gap_ff <= 8'h50
      |-> !tx_line_clock[0] && gap_ff < 8'h04)
      else $error("tx signalling moved away from falling clock");
   a_pulse_launch: assert property (
      $rose(tx_frame_pulse[0]) && cfg_ff[0] && !cfg_ff[2] |-> !tx_line_clock[0])
      else $error("tx frame pulse rose with clock high");
   a_los_level: assert property (
      cfg_ff[0] && cfg_ff[2] && quiet_ff == 3'h7 |-> tx_signalling_or_los[0] == lvl_ff)
      else $error("unstructured los level wrong");
   a_unmapped_err: assert property (
      psel && penable && paddr >= 12'h0A0 |-> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_irq_view: assert property (
      acc && !pwrite && paddr == tps_pkg::OFS_STATUS |-> irq == |(prdata[15:0] & mask_ff))
      else $error("irq disagrees with status and mask");
   a_irq_drop: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2))
      else $error("irq fell without status read or mask write");
endmodule
bind tps_top tps_checker #(.NPORT(NPORT)) u_chk (.*);
`default_nettype wire

// File: tps_partner.sv
`timescale 1ns/10ps
`default_nettype none
module tps_partner #(
   parameter int FBITS = 256
) (
   input  wire logic        run,
   input  wire logic [31:0] pat,
   input  wire logic [7:0]  los,
   input  wire logic [7:0]  tx_line_clock,
   input  wire logic [7:0]  tx_frame_pulse,
   input  wire logic [7:0]  tx_pcm_data,
   input  wire logic [7:0]  tx_signalling_or_los,
   output logic      [7:0]  rx_line_clock,
   output logic      [7:0]  rx_frame_pulse,
   output logic      [7:0]  rx_pcm_data,
   output logic      [7:0]  rx_signalling_or_los,
   output logic      [31:0] seen_dat,
   output logic      [31:0] seen_sig,
   output int               nseen
);
   logic        c = 1'b0;
   logic        d = 1'b0;
   logic        f = 1'b0;
   int          b = 0;
   int          n = 100;
   logic [31:0] sd = 32'h0000_0000;
   logic [31:0] ss = 32'h0000_0000;
   initial nseen = 0;
   // Link clock, still while run is low
   always begin
      #40;
      if (run) c = ~c;
   end
   // Bits and frame pulse change on falling clock
   always @(negedge c) begin
      d = pat[31 - b % 32];
      f = (b == 0);
      b = (b + 1) % FBITS;
   end
   assign rx_line_clock = {8{c}};
   assign rx_frame_pulse = {8{f && run}};
   assign rx_pcm_data = {8{run ? d : ~d}};
   assign rx_signalling_or_los = los;
   // Sample outgoing bits on rising clock
   always @(posedge tx_line_clock[0]) begin
      n = tx_frame_pulse[0] ? 0 : n + 1;
      sd = {sd[30:0], tx_pcm_data[0]};
      ss = {ss[30:0], tx_signalling_or_los[0]};
      if (n == 32) begin
         seen_dat = sd;
         seen_sig = ss;
         nseen++;
      end
   end
endmodule
`default_nettype wire

// File: test_tdm_port_serial_pcm.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((e) !== (a)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_tdm_port_serial_pcm;
   localparam logic [11:0] C1 = tps_pkg::OFS_CTRL1;
   localparam logic [11:0] ST = tps_pkg::OFS_STATUS;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        ce = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, run = 1'b0;
   logic [7:0]  rx_line_clock, rx_frame_pulse, rx_pcm_data, rx_signalling_or_los;
   logic [7:0]  tx_line_clock, tx_frame_pulse, tx_pcm_data, tx_signalling_or_los;
   logic [7:0]  los = 8'h00;
   logic [31:0] pat = 32'h0000_0000;
   logic [31:0] seen_dat, seen_sig, tw;
   logic [65:0] q[$];
   logic [65:0] e;
   logic [5:0]  modes[5] = '{6'h11, 6'h0B, 6'h23, 6'h01, 6'h07};
   int          nseen, n0, cyc = 0, failures = 0, compares = 0;
   always #2 pclk = ~pclk;
   tps_top dut (.*);
   tps_partner u_far (.*);
   task automatic finish_test;
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] x, input logic [32:0] m);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      if (!w) q.push_back({x, m});
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 33'h0, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] x, input logic [32:0] m);
      xfer(1'b0, a, 32'h0, x, m);
   endtask
   // Oldest read note against bus result
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         e = q.pop_front();
         `CHK("read", e[65:33] & e[32:0], {pslverr, prdata} & e[32:0])
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(48));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(C1, 33'h0, 33'h1_FFFF_FFFF);
      wr(C1 + 12'h00C, 32'hFFFF_FFFF);
      rd(C1 + 12'h00C, 33'h3F, 33'h1_FFFF_FFFF);
      rd(C1 + 12'h008, 33'h0, 33'h1_FFFF_FFFF);
      rd(12'h0A0, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
      wr(C1 + 12'h00C, 32'h0000_0000);
      tw = $urandom;
      pat <= $urandom;
      wr(tps_pkg::OFS_TXDATA, tw);
      wr(C1 + 12'h004, 32'h0000_0001);
      wr(tps_pkg::OFS_MASK, 32'h0000_0001);
      n0 = nseen;
      run <= 1'b1;
      wr(C1, 32'h0000_0003);
      for (int k = 0; k < 40000 && nseen == n0; k++) @(posedge pclk);
      `CHK("tx data", tw, seen_dat)
      `CHK("tx sig", tw, seen_sig)
      `CHK("irq frame", 1'b1, irq)
      rd(tps_pkg::OFS_RXDATA, {1'b0, pat}, 33'h1_FFFF_FFFF);
      rd(ST, 33'h1, 33'h1);
      `CHK("irq cleared", 1'b0, irq)
      wr(tps_pkg::OFS_CTRL3, 32'h0000_0001);
      foreach (modes[i]) begin
         wr(C1, 32'h0000_0000);
         repeat (100) @(posedge pclk);
         wr(C1, {26'h0, modes[i]});
         repeat (400) @(posedge pclk);
      end
      `CHK("los level", 1'b1, tx_signalling_or_los[0])
      wr(tps_pkg::OFS_MASK, 32'h0000_0100);
      rd(ST, 33'h0, 33'h0);
      repeat (6000) @(posedge pclk);
      rd(ST, 33'h0, 33'h1);
      `CHK("irq masked", 1'b0, irq)
      los <= 8'h01;
      repeat (10) @(posedge pclk);
      `CHK("irq los", 1'b1, irq)
      rd(tps_pkg::OFS_LOS, 33'h1, 33'h1);
      rd(ST, 33'h100, 33'h101);
      rd(ST, 33'h0, 33'h100);
      wr(tps_pkg::OFS_CTRL3, 32'h0000_0000);
      repeat (10) @(posedge pclk);
      `CHK("los level", 1'b0, tx_signalling_or_los[0])
      finish_test();
   end
endmodule
`default_nettype wire
